// file: hw/iss_serializer.sv
`timescale 1ns/1ps
// How it works
// - one eight-stage parallel-in serial-out register
// - low load strobe loads all stages unconditionally
// - high load strobe blocks parallel capture
// - shift on clock rise, strobe high, gate low
// - gate high with strobe high holds register contents
// - stages move toward output, cascade input enters
// - eight shifts empty register, cascade bits follow
// - load captures field inputs zero to seven
// - over first trip point pull flag low
// - over second trip point float serial and flag outputs
// - floating flag still reads low via pulldown
// - register end drives the serial output
// - field level latched after selected filter time
module iss_serializer
    import iss_pkg::*;
#(
    parameter int N          = CHANNELS,
    parameter int TICK_COUNT = TICK_CYCLES
)
(
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire logic [N-1:0]  field_input,
    input  wire logic          filter_select_hi,
    input  wire logic          filter_select_lo,
    input  wire logic          load_strobe_n,
    input  wire logic          shift_clock,
    input  wire logic          shift_gate_n,
    input  wire logic          cascade_serial_in,
    input  wire logic          temp_over_first,
    input  wire logic          temp_over_second,
    output logic               serial_out_line,
    output logic               serial_out_oe_n,
    output logic               overtemp_flag_n,
    output logic               overtemp_flag_oe_n,
    output logic               overtemp_pulldown
);
    logic [N-1:0]    latched_input_lines;
    logic            tick;
    iss_filt_sel_t   filterSel;
    logic [N-1:0]    shift_reg;
    logic [N-1:0]    shift_next;
    logic            shiftClk_reg;
    logic            shiftOut_next;
    iss_temp_state_t temp_reg;
    iss_temp_state_t temp_next;
    logic            flagN_next;
    logic            flagOeN_next;
    logic            soOeN_next;
    logic            pull_next;

    assign filterSel = iss_filt_sel_t'({filter_select_hi, filter_select_lo});

    iss_tick_div #(
        .CYCLES (TICK_COUNT)
    ) u_tick (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tick    (tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_filt
            iss_debounce u_db (
                .sys_clk    (sys_clk),
                .rst_b      (rst_b),
                .tick       (tick),
                .filterSel  (filterSel),
                .fieldIn    (field_input[gi]),
                .latchedOut (latched_input_lines[gi])
            );
        end
    endgenerate

    // shift register: index N-1 is the stage nearest the output
    always_comb
    begin
        shift_next = shift_reg;
        if (!load_strobe_n)
            shift_next = latched_input_lines;
        else if (shift_clock && !shiftClk_reg && !shift_gate_n)
            shift_next = {shift_reg[N-2:0], cascade_serial_in};
        // strobe high and no qualified edge: hold, no capture
        shiftOut_next = shift_next[N-1];
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_reg       <= SHIFT_RESET;
            shiftClk_reg    <= 1'b0;
            serial_out_line <= 1'b0;
        end
        else
        begin
            shift_reg       <= shift_next;
            shiftClk_reg    <= shift_clock;
            serial_out_line <= shiftOut_next;
        end
    end

    // thermal supervisor
    always_comb
    begin
        if (temp_over_second)
            temp_next = ISS_TEMP_SHDN;
        else if (temp_over_first)
            temp_next = ISS_TEMP_HOT;
        else
            temp_next = ISS_TEMP_OK;
        case (temp_next)
            ISS_TEMP_OK:
            begin
                flagN_next   = 1'b1;
                flagOeN_next = 1'b0;
                soOeN_next   = 1'b0;
                pull_next    = 1'b0;
            end
            ISS_TEMP_HOT:
            begin
                flagN_next   = 1'b0;
                flagOeN_next = 1'b0;
                soOeN_next   = 1'b0;
                pull_next    = 1'b0;
            end
            ISS_TEMP_SHDN:
            begin
                flagN_next   = 1'b0;
                flagOeN_next = 1'b1;
                soOeN_next   = 1'b1;
                pull_next    = 1'b1;
            end
            default:
            begin
                flagN_next   = 1'b1;
                flagOeN_next = 1'b0;
                soOeN_next   = 1'b0;
                pull_next    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            temp_reg           <= ISS_TEMP_OK;
            overtemp_flag_n    <= 1'b1;
            overtemp_flag_oe_n <= 1'b0;
            serial_out_oe_n    <= 1'b0;
            overtemp_pulldown  <= 1'b0;
        end
        else
        begin
            temp_reg           <= temp_next;
            overtemp_flag_n    <= flagN_next;
            overtemp_flag_oe_n <= flagOeN_next;
            serial_out_oe_n    <= soOeN_next;
            overtemp_pulldown  <= pull_next;
        end
    end
endmodule

// file: hw/iss_pkg.sv
package iss_pkg;
    localparam int CHANNELS      = 8;
    localparam int CLK_FREQ_HZ   = 50_000_000;
    localparam int FILT_LONG_MS  = 3;
    localparam int FILT_SHORT_MS = 1;
    localparam int TICK_CYCLES   = CLK_FREQ_HZ / 1000;
    localparam int FILT_LONG_TICKS  = FILT_LONG_MS;
    localparam int FILT_SHORT_TICKS = FILT_SHORT_MS;
    localparam int TICK_W        = 16;
    localparam int FILT_CNT_W    = 3;
    localparam logic [CHANNELS-1:0] SHIFT_RESET = 8'h00;

    typedef enum logic [1:0]
    {
        ISS_FILT_BYPASS   = 2'b01,
        ISS_FILT_1MS      = 2'b10,
        ISS_FILT_3MS      = 2'b11,
        ISS_FILT_RESERVED = 2'b00
    } iss_filt_sel_t;

    typedef enum logic [1:0]
    {
        ISS_TEMP_OK   = 2'b00,
        ISS_TEMP_HOT  = 2'b01,
        ISS_TEMP_SHDN = 2'b11
    } iss_temp_state_t;
endpackage

// file: hw/iss_tick_div.sv
`timescale 1ns/1ps
module iss_tick_div
    import iss_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
)
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    output logic      tick
);
    logic [TICK_W-1:0] cnt_reg;
    logic [TICK_W-1:0] cnt_next;
    logic              tick_next;

    always_comb
    begin
        tick_next = 1'b0;
        cnt_next  = cnt_reg + 16'h0001;
        if (cnt_reg == TICK_W'(CYCLES - 1))
        begin
            cnt_next  = 16'h0000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg <= 16'h0000;
            tick    <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick    <= tick_next;
        end
    end
endmodule

// file: hw/iss_debounce.sv
`timescale 1ns/1ps
module iss_debounce
    import iss_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire logic          tick,
    input  wire iss_filt_sel_t filterSel,
    input  wire logic          fieldIn,
    output logic               latchedOut
);
    logic                  stable_reg;
    logic                  stable_next;
    logic [FILT_CNT_W-1:0] cnt_reg;
    logic [FILT_CNT_W-1:0] cnt_next;
    logic [FILT_CNT_W-1:0] limit;

    always_comb
    begin
        limit = (filterSel == ISS_FILT_1MS) ? FILT_CNT_W'(FILT_SHORT_TICKS)
                                            : FILT_CNT_W'(FILT_LONG_TICKS);
        stable_next = stable_reg;
        cnt_next    = cnt_reg;
        if (filterSel == ISS_FILT_BYPASS)
        begin
            stable_next = fieldIn;
            cnt_next    = '0;
        end
        else if (fieldIn == stable_reg)
            cnt_next = '0;
        else if (tick)
        begin
            // count whole ticks; reserved code acts as the long filter
            if (cnt_reg + 3'd1 >= limit)
            begin
                stable_next = fieldIn;
                cnt_next    = '0;
            end
            else
                cnt_next = cnt_reg + 3'd1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stable_reg <= 1'b0;
            cnt_reg    <= '0;
        end
        else
        begin
            stable_reg <= stable_next;
            cnt_reg    <= cnt_next;
        end
    end

    assign latchedOut = stable_reg;
endmodule

// file: bench/iss_serializer_assertions.sv
`timescale 1ns/1ps
module iss_serializer_checker #(parameter int N = 8)
(
    input wire logic         sys_clk,
    input wire logic         rst_b,
    input wire logic [N-1:0] field_input,
    input wire logic         filter_select_hi,
    input wire logic         filter_select_lo,
    input wire logic         load_strobe_n,
    input wire logic         shift_clock,
    input wire logic         shift_gate_n,
    input wire logic         temp_over_first,
    input wire logic         temp_over_second,
    input wire logic         serial_out_line,
    input wire logic         serial_out_oe_n,
    input wire logic         overtemp_flag_n,
    input wire logic         overtemp_flag_oe_n,
    input wire logic         overtemp_pulldown
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_gate_hold: assert property (
        load_strobe_n && shift_gate_n |=> $stable(serial_out_line)) else $error("gated move");
    a_no_edge: assert property (
        load_strobe_n && !(shift_clock && !$past(shift_clock)) |=> $stable(serial_out_line))
        else $error("move without edge");
    a_load_steady: assert property (
        (!load_strobe_n && $stable(field_input) && !filter_select_hi && filter_select_lo) [*3]
        |-> serial_out_line == field_input[N-1]) else $error("load not following");
    a_hot_flag: assert property (
        temp_over_first && !temp_over_second |=> !overtemp_flag_n) else $error("flag not low");
    a_cool_flag: assert property (
        !temp_over_first && !temp_over_second |=> overtemp_flag_n) else $error("flag not high");
    a_shdn_float: assert property (
        temp_over_second |=> serial_out_oe_n && overtemp_flag_oe_n) else $error("not floated");
    a_shdn_pull: assert property (
        temp_over_second |=> overtemp_pulldown) else $error("no pulldown");
    a_normal_drive: assert property (
        !temp_over_second |=> !serial_out_oe_n && !overtemp_flag_oe_n && !overtemp_pulldown)
        else $error("not driving");
endmodule
bind iss_serializer iss_serializer_checker #(.N(N)) chk_u (.*);

// file: bench/iss_host_model.sv
`timescale 1ns/1ps
module iss_host_model
(
    input  wire logic sys_clk,
    input  wire logic serial_out_line,
    output logic      load_strobe_n,
    output logic      shift_clock,
    output logic      shift_gate_n,
    output logic      cascade_serial_in
);
    logic [7:0] cascWord = 8'h96;
    initial
    begin
        load_strobe_n = 1'h1;
        shift_clock = 1'h0;
        shift_gate_n = 1'h1;
        cascade_serial_in = 1'h0;
    end
    // hold the register in parallel load until released
    task automatic load_low();
        @(negedge sys_clk) load_strobe_n = 1'h0;
    endtask
    task automatic load_high();
        @(negedge sys_clk) load_strobe_n = 1'h1;
    endtask
    // load pulse, then n clock pulses, bits kept first-out first
    task automatic read_bits(input int n, input logic gateN, output logic [15:0] bits);
        bits = '0;
        @(negedge sys_clk) load_strobe_n = 1'h0;
        @(negedge sys_clk) load_strobe_n = 1'h1;
        shift_gate_n = gateN;
        for (int i = 0; i < n; i++)
        begin
            bits = {bits[14:0], serial_out_line};
            cascade_serial_in = cascWord[7 - (i % 8)];
            shift_clock = 1'h1;
            @(negedge sys_clk) shift_clock = 1'h0;
            @(negedge sys_clk);
        end
        shift_gate_n = 1'h1;
    endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import iss_pkg::*;
    logic        sys_clk, rst_b, filter_select_hi, filter_select_lo, temp_over_first;
    logic        temp_over_second, load_strobe_n, shift_clock, shift_gate_n, cascade_serial_in;
    logic        serial_out_line, serial_out_oe_n, overtemp_flag_n, overtemp_flag_oe_n;
    logic        overtemp_pulldown;
    logic [7:0]  field_input;
    logic [15:0] got;
    int          fails, checked;
    iss_serializer #(.TICK_COUNT(10)) dut_u (.*);
    iss_host_model host_u (.*);
    task automatic check(input logic [15:0] exp, input logic [15:0] act);
        checked++;
        if (act !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_shift(input logic [7:0] v);
        @(negedge sys_clk) field_input = v;
        repeat (3) @(negedge sys_clk);
        host_u.read_bits(16, 1'h0, got);
        check({v, 8'h96}, got);
        if (v[7] == v[6])
            check({15'h0000, got[15]}, {15'h0000, got[14]});
        $display("shift test done");
    endtask
    task automatic t_gate();
        @(negedge sys_clk) field_input = 8'h80;
        repeat (3) @(negedge sys_clk);
        host_u.read_bits(4, 1'h1, got);
        check(16'h000F, got);
        $display("gate test done");
    endtask
    // load held low: output follows the filtered field level
    task automatic t_load();
        host_u.load_low();
        @(negedge sys_clk) field_input = 8'h80;
        repeat (3) @(negedge sys_clk);
        check(16'h0001, {15'h0000, serial_out_line});
        field_input = 8'h00;
        repeat (3) @(negedge sys_clk);
        check(16'h0000, {15'h0000, serial_out_line});
        host_u.load_high();
        $display("load test done");
    endtask
    // settle low, raise all, check old level early when early is nonzero, and new level late
    task automatic t_filter(input logic [1:0] sel, input int early, input int late);
        @(negedge sys_clk) {filter_select_hi, filter_select_lo} = sel;
        field_input = 8'h00;
        repeat (60) @(negedge sys_clk);
        field_input = 8'hFF;
        if (early > 0)
        begin
            repeat (early) @(negedge sys_clk);
            host_u.read_bits(1, 1'h0, got);
            check(16'h0000, got);
        end
        repeat (late) @(negedge sys_clk);
        host_u.read_bits(1, 1'h0, got);
        check(16'h0001, got);
        $display("filter test done");
    endtask
    task automatic t_thermal();
        @(negedge sys_clk) temp_over_first = 1'h1;
        repeat (2) @(negedge sys_clk);
        check(16'h0000, {12'h000, overtemp_flag_n, overtemp_flag_oe_n, serial_out_oe_n,
            overtemp_pulldown});
        temp_over_second = 1'h1;
        repeat (2) @(negedge sys_clk);
        check(16'h0007, {13'h0000, overtemp_flag_oe_n, serial_out_oe_n, overtemp_pulldown});
        {temp_over_first, temp_over_second} = 2'h0;
        repeat (2) @(negedge sys_clk);
        check(16'h0008, {12'h000, overtemp_flag_n, overtemp_flag_oe_n, serial_out_oe_n,
            overtemp_pulldown});
        $display("thermal test done");
    endtask
    initial
    begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        #100000;
        fails++;
        stop_test();
    end
    initial
    begin
        {rst_b, filter_select_hi, temp_over_first, temp_over_second} = 4'h0;
        filter_select_lo = 1'h1;
        field_input = 8'h00;
        repeat (20) @(negedge sys_clk);
        rst_b = 1'h1;
        t_shift(8'hA5);
        t_shift(8'h5A);
        t_shift(8'hC3);
        t_gate();
        t_load();
        t_filter(2'h2, 0, 15);
        t_filter(2'h3, 12, 50);
        t_filter(2'h0, 12, 50);
        t_thermal();
        stop_test();
    end
endmodule
